//--- wci_pkg.sv
package wci_pkg;
   // instruction command field
   localparam logic [2:0] CMD_WIPER = 3'h0;
   localparam logic [2:0] CMD_NV = 3'h1;
   localparam logic [2:0] CMD_WP = 3'h2;
   localparam logic [2:0] CMD_NOP = 3'h4;
   localparam logic [2:0] CMD_RESTORE = 3'h5;
   localparam logic [2:0] CMD_STORE = 3'h6;
   // internal addresses of the read-only tolerance bytes
   localparam logic [4:0] TOL_ADDR_SIGN_INT = 5'h1e;
   localparam logic [4:0] TOL_ADDR_FRAC = 5'h1f;
   // factory tolerance defaults, arbitrary
   localparam logic [7:0] TOL_SIGN_INT_DEF = 8'h00;
   localparam logic [7:0] TOL_FRAC_DEF = 8'h00;
   localparam logic [5:0] WIPER_MIDSCALE = 6'h20;
   // three-state strap codes; the code is also the address offset
   localparam logic [1:0] PIN_LOW = 2'h0;
   localparam logic [1:0] PIN_FLOAT = 2'h1;
   localparam logic [1:0] PIN_HIGH = 2'h2;
   localparam logic [6:0] ADDR_BASE_LOW = 7'h18;
   localparam logic [6:0] ADDR_BASE_FLOAT = 7'h29;
   localparam logic [6:0] ADDR_BASE_HIGH = 7'h4c;
   // byte slots within a write transaction
   localparam logic [1:0] SLOT_ADDR = 2'h0;
   localparam logic [1:0] SLOT_INSTR = 2'h1;
   localparam logic [1:0] SLOT_DATA = 2'h2;
   localparam logic [1:0] STRAP_WAIT = 2'h2;
   typedef enum logic [2:0] {
      ST_IDLE, ST_RX, ST_ACKW, ST_ACK, ST_TX, ST_MACK
   } wci_dev_state_e;
   // controller registers on the software bus
   localparam logic [3:0] HOST_CMD_OFF = 4'h0;
   localparam logic [3:0] HOST_STAT_OFF = 4'h4;
   localparam logic [1:0] OP_START = 2'h0;
   localparam logic [1:0] OP_STOP = 2'h1;
   localparam logic [1:0] OP_WRITE = 2'h2;
   localparam logic [1:0] OP_READ = 2'h3;
   localparam int CMD_OP_POS = 8;
   localparam int CMD_NACK_POS = 10;
   localparam logic [3:0] SLOTS_COND = 4'h1;
   localparam logic [3:0] SLOTS_BYTE = 4'h9;
   localparam int QUARTER_DEF = 6;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : wci_pkg

//--- wci_if.sv
`timescale 1ns/1ps
interface wci_if;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic scl;
   logic sda;
   // open-drain lines with pull-ups
   assign scl = ~(host_scl_oe & ~host_scl_o);
   assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
   modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
   modport host (
      input scl,
      input sda,
      output host_scl_o,
      output host_scl_oe,
      output host_sda_o,
      output host_sda_oe
   );
endinterface : wci_if

//--- wci_sync.sv
`timescale 1ns/1ps
module wci_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // asynchronous in, synchronous out
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta <= RST;
         q_o <= RST;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule : wci_sync

//--- wci_device.sv
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
// How it works
// - straps pick one of nine addresses
// - start, address, instruction, data; each acked
// - command field selects the operation
// - wiper write loads low six bits
// - nonvolatile command writes the stored copy
// - write protect bit is data LSB
// - store copies wiper to stored on stop
// - restore copies stored to wiper on stop
// - wiper read returns zero-padded six bits
// - nonvolatile read returns stored six bits
// - pointer kept for direct reads
// - two read-only tolerance bytes at 1e/1f
// - tolerance read auto-increments 1e to 1f
// - first byte: sign MSB, integer below
// - second byte: fraction in 1/256 units
// - tolerance locations ignore writes
// - blank memory means midscale wiper at power-up
// - straps latched once after reset
// - every further wiper data byte updates
module wci_device #(
   parameter logic [7:0] TOL_SIGN_INT = wci_pkg::TOL_SIGN_INT_DEF,
   parameter logic [7:0] TOL_FRAC = wci_pkg::TOL_FRAC_DEF
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // serial link
   wci_if.device bus,
   // straps and nonvolatile image
   input wire logic [1:0] addr_select_pin_low_i,
   input wire logic [1:0] addr_select_pin_high_i,
   input wire logic nv_blank_i,
   input wire logic [5:0] nv_image_i,
   // potentiometer state
   output logic [5:0] wiper_register_o,
   output logic [5:0] stored_wiper_o,
   output logic write_protect_o,
   output logic nv_write_o
);
   logic [12:0] sq;
   logic scl_s;
   logic sda_s;
   logic [1:0] ad_low;
   logic [1:0] ad_high;
   logic nv_blank;
   logic [5:0] nv_image;
   logic scl_d;
   logic sda_d;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   wci_pkg::wci_dev_state_e st;
   logic [2:0] bitcnt;
   logic [7:0] sh;
   logic [1:0] slot;
   logic rd_mode;
   logic sda_oe;
   logic [2:0] cmd;
   logic [4:0] ia;
   logic pend;
   logic [1:0] strap_cnt;
   logic strapped;
   logic [6:0] own_addr;
   logic [6:0] strap_base;
   logic [6:0] strap_addr;
   logic [7:0] rx_byte;
   logic addr_hit;
   logic byte_done;
   logic instr_done;
   logic data_done;
   logic mack_ok;
   logic is_tol;
   logic nv_cmd;
   logic [7:0] rd_byte;
   logic store_go;
   logic restore_go;

   wci_sync #(.W(13), .RST(13'h1800)) u_sync (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .d_i({bus.scl, bus.sda, addr_select_pin_low_i, addr_select_pin_high_i,
            nv_blank_i, nv_image_i}),
      .q_o(sq)
   );
   assign scl_s = sq[12];
   assign sda_s = sq[11];
   assign ad_low = sq[10:9];
   assign ad_high = sq[8:7];
   assign nv_blank = sq[6];
   assign nv_image = sq[5:0];

   // bus conditions from the synchronised lines
   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   assign start_c = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_c = scl_s & scl_d & ~sda_d & sda_s;

   // high pin picks the group, low pin the offset within it
   assign strap_base = (ad_high == wci_pkg::PIN_LOW) ? wci_pkg::ADDR_BASE_LOW :
                       (ad_high == wci_pkg::PIN_FLOAT) ? wci_pkg::ADDR_BASE_FLOAT :
                       wci_pkg::ADDR_BASE_HIGH;
   assign strap_addr = strap_base + {5'h00, ad_low};

   assign rx_byte = {sh[6:0], sda_s};
   assign addr_hit = (rx_byte[7:1] == own_addr);
   assign byte_done = (st == wci_pkg::ST_RX) && scl_rise && (bitcnt == 3'h7);
   assign instr_done = byte_done && (slot == wci_pkg::SLOT_INSTR);
   assign data_done = byte_done && (slot == wci_pkg::SLOT_DATA);
   assign mack_ok = (st == wci_pkg::ST_MACK) && scl_rise && !sda_s;
   assign nv_cmd = (cmd == wci_pkg::CMD_NV);
   assign is_tol = (ia == wci_pkg::TOL_ADDR_SIGN_INT) || (ia == wci_pkg::TOL_ADDR_FRAC);
   assign store_go = stop_c && pend && (cmd == wci_pkg::CMD_STORE);
   assign restore_go = stop_c && pend && (cmd == wci_pkg::CMD_RESTORE);

   // don't-care bits of six-bit reads come back as zero
   assign rd_byte = (nv_cmd && ia == wci_pkg::TOL_ADDR_SIGN_INT) ? TOL_SIGN_INT :
                    (nv_cmd && ia == wci_pkg::TOL_ADDR_FRAC) ? TOL_FRAC :
                    nv_cmd ? {2'h0, stored_wiper_o} :
                    {2'h0, wiper_register_o};

   assign bus.dev_sda_o = 1'b0;
   assign bus.dev_sda_oe = sda_oe;

   // byte engine: samples on scl rise, drives on scl fall
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st <= wci_pkg::ST_IDLE;
         bitcnt <= 3'h0;
         sh <= 8'h00;
         slot <= wci_pkg::SLOT_ADDR;
         rd_mode <= 1'b0;
         sda_oe <= 1'b0;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
         if (!strapped) begin
            st <= wci_pkg::ST_IDLE;
         end else if (start_c) begin
            st <= wci_pkg::ST_RX;
            bitcnt <= 3'h0;
            slot <= wci_pkg::SLOT_ADDR;
            sda_oe <= 1'b0;
         end else if (stop_c) begin
            st <= wci_pkg::ST_IDLE;
            sda_oe <= 1'b0;
         end else begin
            case (st)
               wci_pkg::ST_RX: begin
                  if (scl_rise) begin
                     sh <= rx_byte;
                     bitcnt <= bitcnt + 3'h1;
                     if (bitcnt == 3'h7) begin
                        if (slot == wci_pkg::SLOT_ADDR) begin
                           rd_mode <= rx_byte[0];
                        end
                        // a foreign address leaves us idle until the next start
                        st <= (slot == wci_pkg::SLOT_ADDR && !addr_hit) ?
                              wci_pkg::ST_IDLE : wci_pkg::ST_ACKW;
                     end
                  end
               end
               wci_pkg::ST_ACKW: begin
                  if (scl_fall) begin
                     sda_oe <= 1'b1;
                     st <= wci_pkg::ST_ACK;
                  end
               end
               wci_pkg::ST_ACK: begin
                  if (scl_fall) begin
                     if (rd_mode) begin
                        sda_oe <= ~rd_byte[7];
                        sh <= {rd_byte[6:0], 1'b0};
                        bitcnt <= 3'h1;
                        st <= wci_pkg::ST_TX;
                     end else begin
                        sda_oe <= 1'b0;
                        bitcnt <= 3'h0;
                        slot <= (slot == wci_pkg::SLOT_ADDR) ?
                                wci_pkg::SLOT_INSTR : wci_pkg::SLOT_DATA;
                        st <= wci_pkg::ST_RX;
                     end
                  end
               end
               wci_pkg::ST_TX: begin
                  if (scl_fall) begin
                     if (bitcnt == 3'h0) begin
                        sda_oe <= 1'b0;
                        st <= wci_pkg::ST_MACK;
                     end else begin
                        sda_oe <= ~sh[7];
                        sh <= {sh[6:0], 1'b0};
                        bitcnt <= bitcnt + 3'h1;
                     end
                  end
               end
               wci_pkg::ST_MACK: begin
                  // no-acknowledge ends the read; acknowledge sends another byte
                  if (scl_rise) begin
                     st <= sda_s ? wci_pkg::ST_IDLE : wci_pkg::ST_ACK;
                  end
               end
               default: begin
                  st <= wci_pkg::ST_IDLE;
               end
            endcase
         end
      end
   end

   // strap latch and potentiometer registers
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         strap_cnt <= 2'h0;
         strapped <= 1'b0;
         own_addr <= wci_pkg::ADDR_BASE_LOW;
         wiper_register_o <= wci_pkg::WIPER_MIDSCALE;
         stored_wiper_o <= wci_pkg::WIPER_MIDSCALE;
         write_protect_o <= 1'b0;
         nv_write_o <= 1'b0;
         cmd <= wci_pkg::CMD_WIPER;
         ia <= 5'h00;
         pend <= 1'b0;
      end else begin
         nv_write_o <= 1'b0;
         if (!strapped) begin
            // synchroniser must fill before the straps mean anything
            if (strap_cnt == wci_pkg::STRAP_WAIT) begin
               strapped <= 1'b1;
               own_addr <= strap_addr;
               stored_wiper_o <= nv_image;
               wiper_register_o <= nv_blank ? wci_pkg::WIPER_MIDSCALE : nv_image;
            end else begin
               strap_cnt <= strap_cnt + 2'h1;
            end
         end else if (start_c) begin
            pend <= 1'b0;
         end else if (store_go) begin
            pend <= 1'b0;
            if (!write_protect_o) begin
               stored_wiper_o <= wiper_register_o;
               nv_write_o <= 1'b1;
            end
         end else if (restore_go) begin
            pend <= 1'b0;
            wiper_register_o <= stored_wiper_o;
         end else if (instr_done) begin
            cmd <= rx_byte[7:5];
            ia <= rx_byte[4:0];
            pend <= (rx_byte[7:5] == wci_pkg::CMD_STORE) ||
                    (rx_byte[7:5] == wci_pkg::CMD_RESTORE);
         end else if (data_done) begin
            case (cmd)
               wci_pkg::CMD_WIPER: begin
                  wiper_register_o <= rx_byte[5:0];
               end
               wci_pkg::CMD_NV: begin
                  if (!write_protect_o && !is_tol) begin
                     stored_wiper_o <= rx_byte[5:0];
                     nv_write_o <= 1'b1;
                  end
               end
               wci_pkg::CMD_WP: begin
                  write_protect_o <= rx_byte[0];
               end
               default: begin
                  // nop, restore, store and unlisted codes ignore data
                  pend <= pend;
               end
            endcase
         end else if (mack_ok && nv_cmd && ia == wci_pkg::TOL_ADDR_SIGN_INT) begin
            ia <= wci_pkg::TOL_ADDR_FRAC;
         end
      end
   end
endmodule : wci_device

//--- wci_host.sv
`timescale 1ns/1ps
module wci_host #(
   parameter int QUARTER = wci_pkg::QUARTER_DEF
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // serial link
   wci_if.host bus,
   // axi4-lite write
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic sda_s;
   logic wr_go;
   logic wr_cmd;
   logic wr_map;
   logic take;
   logic rd_go;
   logic rd_map;
   logic [31:0] rd_val;
   logic busy;
   logic [1:0] op;
   logic [3:0] slots;
   logic [1:0] ph;
   logic [7:0] qcnt;
   logic tick;
   logic [8:0] sh;
   logic [8:0] rx;
   logic [10:0] cmd_reg;
   logic scl_lvl;
   logic sda_lvl;
   logic b1;
   logic b2;
   logic is_byte;

   wci_sync #(.W(1), .RST(1'b1)) u_sync (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .d_i(bus.sda),
      .q_o(sda_s)
   );

   // both write channels are taken together, once the response is free
   assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign wr_cmd = (s_axi_awaddr[3:2] == wci_pkg::HOST_CMD_OFF[3:2]);
   assign wr_map = wr_cmd || (s_axi_awaddr[3:2] == wci_pkg::HOST_STAT_OFF[3:2]);
   // writes lacking either of the two low byte strobes and writes while busy are dropped
   assign take = wr_go & wr_cmd & (s_axi_wstrb[1:0] == 2'h3) & ~busy;
   assign s_axi_arready = ~s_axi_rvalid;
   assign rd_go = s_axi_arvalid & ~s_axi_rvalid;
   assign rd_map = (s_axi_araddr[3:2] == wci_pkg::HOST_CMD_OFF[3:2]) ||
                   (s_axi_araddr[3:2] == wci_pkg::HOST_STAT_OFF[3:2]);
   assign rd_val = (s_axi_araddr[3:2] == wci_pkg::HOST_CMD_OFF[3:2]) ?
                   {21'h00_0000, cmd_reg} :
                   {16'h0000, rx[8:1], 6'h00, rx[0], busy};

   // each slot: scl low, sda to b1, scl high, sda to b2
   assign is_byte = (op == wci_pkg::OP_WRITE) || (op == wci_pkg::OP_READ);
   assign b1 = (op == wci_pkg::OP_START) ? 1'b1 : (op == wci_pkg::OP_STOP) ? 1'b0 : sh[8];
   assign b2 = (op == wci_pkg::OP_START) ? 1'b0 : (op == wci_pkg::OP_STOP) ? 1'b1 : sh[8];
   assign tick = busy && (qcnt == 8'(QUARTER - 1));

   assign bus.host_scl_o = 1'b0;
   assign bus.host_scl_oe = ~scl_lvl;
   assign bus.host_sda_o = 1'b0;
   assign bus.host_sda_oe = ~sda_lvl;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= wci_pkg::RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= wci_pkg::RESP_OKAY;
         s_axi_rdata <= 32'h0000_0000;
      end else begin
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_map ? wci_pkg::RESP_OKAY : wci_pkg::RESP_DECERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_map ? rd_val : 32'h0000_0000;
            s_axi_rresp <= rd_map ? wci_pkg::RESP_OKAY : wci_pkg::RESP_DECERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         busy <= 1'b0;
         op <= wci_pkg::OP_STOP;
         slots <= 4'h0;
         ph <= 2'h0;
         qcnt <= 8'h00;
         sh <= 9'h1ff;
         rx <= 9'h000;
         cmd_reg <= 11'h000;
         scl_lvl <= 1'b1;
         sda_lvl <= 1'b1;
      end else if (take) begin
         busy <= 1'b1;
         cmd_reg <= s_axi_wdata[10:0];
         op <= s_axi_wdata[wci_pkg::CMD_OP_POS +: 2];
         slots <= (s_axi_wdata[9]) ? wci_pkg::SLOTS_BYTE : wci_pkg::SLOTS_COND;
         // read: release all data bits, send own ack or no-acknowledge last
         sh <= (s_axi_wdata[9:8] == wci_pkg::OP_READ) ?
               {8'hff, s_axi_wdata[wci_pkg::CMD_NACK_POS]} : {s_axi_wdata[7:0], 1'b1};
         ph <= 2'h0;
         qcnt <= 8'h00;
         scl_lvl <= 1'b0;
      end else if (busy) begin
         qcnt <= tick ? 8'h00 : qcnt + 8'h01;
         if (tick) begin
            ph <= ph + 2'h1;
            case (ph)
               2'h0: begin
                  sda_lvl <= b1;
               end
               2'h1: begin
                  scl_lvl <= 1'b1;
               end
               2'h2: begin
                  sda_lvl <= b2;
                  if (is_byte) begin
                     rx <= {rx[7:0], sda_s};
                  end
               end
               default: begin
                  sh <= {sh[7:0], 1'b1};
                  slots <= slots - 4'h1;
                  if (slots == 4'h1) begin
                     busy <= 1'b0;
                  end else begin
                     scl_lvl <= 1'b0;
                  end
               end
            endcase
         end
      end
   end
endmodule : wci_host

//--- wci_checker.sv
`timescale 1ns/1ps
module wci_checker (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // link lines
   input wire logic scl,
   input wire logic sda,
   input wire logic host_scl_o,
   input wire logic host_scl_oe,
   input wire logic host_sda_o,
   input wire logic host_sda_oe,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);
   chk_dev_open_drain: assert property (dev_sda_oe |-> !dev_sda_o)
      else $error("device drives sda high");
   chk_host_scl_od: assert property (host_scl_oe |-> !host_scl_o)
      else $error("host drives scl high");
   chk_host_sda_od: assert property (host_sda_oe |-> !host_sda_o)
      else $error("host drives sda high");
   // device may only move sda while the clock is low
   chk_dev_drive_low: assert property ($rose(dev_sda_oe) |-> !scl)
      else $error("device pulled sda with scl high");
   chk_dev_stable_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
      else $error("device sda changed during scl high");
   chk_dev_ack_hold: assert property ($rose(dev_sda_oe) |-> ##[1:12] $rose(scl) ##0 !sda)
      else $error("device low not seen at scl rise");
   chk_scl_high_min: assert property ($rose(scl) |-> scl [*6])
      else $error("scl high phase too short");
   chk_scl_low_min: assert property ($fell(scl) |-> !scl [*6])
      else $error("scl low phase too short");
   chk_reset_idle: assert property ($rose(rstn_i) |-> !dev_sda_oe && !host_scl_oe)
      else $error("line driven after reset");
endmodule : wci_checker

//--- wci_bench.sv
`timescale 1ns/1ps
module wci_bench;
   localparam logic [7:0] TOL_SI = 8'h9c;
   localparam logic [7:0] TOL_FR = 8'h0f;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [3:0] awaddr = 4'h0;
   logic [3:0] araddr = 4'h0;
   logic [3:0] wstrb = 4'hf;
   logic [31:0] wdata = 32'h0000_0000;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [1:0] hi_sel = 2'h0;
   logic [1:0] lo_sel = 2'h0;
   logic nv_blank = 1'b1;
   logic [5:0] nv_img = 6'h15;
   logic [5:0] wiper, stored;
   logic wp;
   logic nvw;
   logic [6:0] dev_addr;
   logic [6:0] addr_tab [3] = '{7'h18, 7'h2a, 7'h4e};
   int err_total = 0;
   int n_tests = 0;
   int cycles = 0;
   int nv_writes = 0;
   always #2.5 clk_i = ~clk_i;
   wci_if bus();
   wci_host #(.QUARTER(4)) i_wci_host (.clk_i(clk_i), .rstn_i(rstn_i), .bus(bus),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   wci_device #(.TOL_SIGN_INT(TOL_SI), .TOL_FRAC(TOL_FR)) i_wci_device (.clk_i(clk_i),
      .rstn_i(rstn_i), .bus(bus), .addr_select_pin_low_i(lo_sel),
      .addr_select_pin_high_i(hi_sel), .nv_blank_i(nv_blank), .nv_image_i(nv_img),
      .wiper_register_o(wiper), .stored_wiper_o(stored), .write_protect_o(wp),
      .nv_write_o(nvw));
   wci_checker i_wci_checker (.clk_i(clk_i), .rstn_i(rstn_i), .scl(bus.scl), .sda(bus.sda),
      .host_scl_o(bus.host_scl_o), .host_scl_oe(bus.host_scl_oe),
      .host_sda_o(bus.host_sda_o), .host_sda_oe(bus.host_sda_oe),
      .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe));
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : conclude
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge clk_i); while (awready !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge clk_i); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk_i); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk_i); while (rvalid !== 1'b1);
      d = rdata;
      rready <= 1'b0;
   endtask : axi_rd
   // one link step, then poll until the host is idle
   task automatic op(input logic [1:0] o, input logic [7:0] b, input logic nk,
                     output logic [31:0] s);
      logic [1:0] r;
      axi_wr(wci_pkg::HOST_CMD_OFF, {21'h0, nk, o, b}, r);
      do axi_rd(wci_pkg::HOST_STAT_OFF, s); while (s[0] !== 1'b0);
   endtask : op
   task automatic cond(input logic [1:0] o);
      logic [31:0] s;
      op(o, 8'h00, 1'b0, s);
   endtask : cond
   task automatic wb(input logic [7:0] b, input logic nak);
      logic [31:0] s;
      op(wci_pkg::OP_WRITE, b, 1'b0, s);
      chk({7'h0, s[1]}, {7'h0, nak});
   endtask : wb
   task automatic xfer(input logic [7:0] ins, input logic [7:0] d, input bit hasd);
      cond(wci_pkg::OP_START);
      wb({dev_addr, 1'b0}, 1'b0);
      wb(ins, 1'b0);
      if (hasd)
         wb(d, 1'b0);
      cond(wci_pkg::OP_STOP);
   endtask : xfer
   task automatic rd2(input logic [7:0] ins, input bit dummy, output logic [7:0] r0, r1);
      logic [31:0] s;
      if (dummy) begin
         cond(wci_pkg::OP_START);
         wb({dev_addr, 1'b0}, 1'b0);
         wb(ins, 1'b0);
      end
      cond(wci_pkg::OP_START);
      wb({dev_addr, 1'b1}, 1'b0);
      op(wci_pkg::OP_READ, 8'h00, 1'b0, s);
      r0 = s[15:8];
      op(wci_pkg::OP_READ, 8'h00, 1'b1, s);
      r1 = s[15:8];
      cond(wci_pkg::OP_STOP);
   endtask : rd2
   always @(posedge clk_i) begin
      cycles++;
      if (nvw === 1'b1) begin
         nv_writes++;
      end
      if (cycles == 60000) begin
         err_total++;
         conclude();
      end
   end
   initial begin
      logic [7:0] a, b;
      logic [1:0] r;
      logic [31:0] w;
      for (int c = 0; c < 3; c++) begin
         hi_sel <= 2'(c);
         lo_sel <= 2'(c);
         nv_blank <= (c == 0);
         dev_addr = addr_tab[c];
         rstn_i <= 1'b0;
         repeat (6) @(posedge clk_i);
         rstn_i <= 1'b1;
         repeat (8) @(posedge clk_i);
         chk({2'h0, wiper}, (c == 0) ? 8'h20 : 8'h15);
         // straps move after power-up; the latched address must hold
         hi_sel <= 2'h0;
         lo_sel <= 2'h2;
         cond(wci_pkg::OP_START);
         wb({dev_addr + 7'h01, 1'b0}, 1'b1);
         cond(wci_pkg::OP_STOP);
         xfer(8'h00, 8'h2e, 1'b1);
         chk({2'h0, wiper}, 8'h2e);
      end
      cond(wci_pkg::OP_START);
      wb({dev_addr, 1'b0}, 1'b0);
      wb(8'h00, 1'b0);
      wb(8'he5, 1'b0);
      chk({2'h0, wiper}, 8'h25);
      wb(8'h07, 1'b0);
      chk({2'h0, wiper}, 8'h07);
      cond(wci_pkg::OP_STOP);
      rd2(8'h00, 1'b1, a, b);
      chk(a, 8'h07);
      xfer(8'h20, 8'h11, 1'b1);
      chk({2'h0, stored}, 8'h11);
      rd2(8'h00, 1'b0, a, b);
      chk(a, 8'h11);
      xfer(8'h00, 8'h2a, 1'b1);
      rd2(8'h20, 1'b1, a, b);
      chk(a, 8'h11);
      xfer(8'ha0, 8'h00, 1'b0);
      chk({2'h0, wiper}, 8'h11);
      xfer(8'h00, 8'h07, 1'b1);
      xfer(8'hc0, 8'h00, 1'b0);
      chk({2'h0, stored}, 8'h07);
      xfer(8'h40, 8'h01, 1'b1);
      chk({7'h0, wp}, 8'h01);
      xfer(8'h00, 8'h3c, 1'b1);
      xfer(8'hc0, 8'h00, 1'b0);
      xfer(8'h20, 8'h2d, 1'b1);
      chk({2'h0, stored}, 8'h07);
      xfer(8'h40, 8'h00, 1'b1);
      chk({7'h0, wp}, 8'h00);
      foreach (addr_tab[i]) begin
         xfer((i == 0) ? 8'h80 : (i == 1) ? 8'h60 : 8'he0, 8'h01, 1'b1);
         chk({2'h0, wiper}, 8'h3c);
         chk({2'h0, stored}, 8'h07);
      end
      rd2(8'h3e, 1'b1, a, b);
      chk(a, TOL_SI);
      chk(b, TOL_FR);
      xfer(8'h3e, 8'h55, 1'b1);
      chk({2'h0, stored}, 8'h07);
      rd2(8'h3f, 1'b1, a, b);
      chk(a, TOL_FR);
      rd2(8'h3e, 1'b1, a, b);
      chk(a, TOL_SI);
      // only the nonvolatile data write and the unprotected store reach memory
      chk(8'(nv_writes), 8'h02);
      axi_wr(4'h8, 32'h0000_0000, r);
      chk({6'h0, r}, {6'h0, wci_pkg::RESP_DECERR});
      // a partial command write is answered but must not start a link step
      wstrb <= 4'h1;
      axi_wr(wci_pkg::HOST_CMD_OFF, 32'h0000_0000, r);
      chk({6'h0, r}, {6'h0, wci_pkg::RESP_OKAY});
      wstrb <= 4'hf;
      axi_rd(wci_pkg::HOST_CMD_OFF, w);
      chk(w[15:8], 8'h01);
      conclude();
   end
endmodule : wci_bench
